// ---- hdl/omc_clk_div.sv ----
// Divide-by-four square wave generator for the clock output pin.
`timescale 1ns/10ps
`include "omc_defs.svh"
module omc_clk_div #(
  parameter int DIV_BITS = `OMC_DIV_BITS
) (
  input  wire logic mclk,
  input  wire logic rst,
  omc_div_if.gen    div
);
  logic [DIV_BITS-1:0] count_q;

  // The counter only runs while enabled so the output restarts low on each enable.
  always_ff @(posedge mclk) begin
    if (rst || !div.enable) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  assign div.div_clk = count_q[DIV_BITS-1];
endmodule : omc_clk_div

// ---- hdl/omc_defs.svh ----
// Register map, field positions and reset values of the oscillator and misc control block.
// Operation
// - Config bit zero selects crystal drive mode.
// - Config bit one selects internal oscillator.
// - Internal mode: first pin pulled-up input, bit 0.
// - First pin raises interrupt only when enabled.
// - Internal mode: bit 1 latch drives second pin.
// - Port bits reach pins only in internal mode.
// - Bit 2 puts oscillator/4 on second pin.
// - Bit 7 holds clock low while buffer full.
// - Bit 6 picks pair B ground reference.
// - Bit 5 picks pair A ground reference.
// - Bit 4 routes I2C lines to pair B.
// - Bit 3 selects SMBus input thresholds.
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_ADDR_W        8
`define OMC_DATA_W        8
`define OMC_MISC_ADDR     8'h9E
`define OMC_IRQ_STAT_ADDR 8'hA0
`define OMC_IRQ_MASK_ADDR 8'hA1
`define OMC_MISC_RESET    8'h00
`define OMC_IRQ_RESET     8'h00
`define OMC_MISC_WR_MASK  8'hFE
`define OMC_BIT_PIN1_IN   0
`define OMC_BIT_PIN2_OUT  1
`define OMC_BIT_CLKOUT_EN 2
`define OMC_BIT_SMBUS_TH  3
`define OMC_BIT_ROUTE     4
`define OMC_BIT_GND_A     5
`define OMC_BIT_GND_B     6
`define OMC_BIT_STRETCH   7
`define OMC_EVT_PIN1      0
`define OMC_EVT_STRETCH   1
`define OMC_EVT_W         2
`define OMC_DIV_BITS      2
`define OMC_SYNC_W        5
`endif

// ---- hdl/omc_div_if.sv ----
// Connection between the control block and its clock divider.
`timescale 1ns/10ps
interface omc_div_if;
  logic enable;
  logic div_clk;
  modport gen (input enable, output div_clk);
  modport user (output enable, input div_clk);
endinterface : omc_div_if

// ---- hdl/omc_misc_ctrl.sv ----
// Oscillator mode selection, misc pin control and serial pin routing.
`timescale 1ns/10ps
`include "omc_defs.svh"
module omc_misc_ctrl #(
  parameter int ADDR_W = `OMC_ADDR_W,
  parameter int DATA_W = `OMC_DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              osc_select_cfg,
  output logic                   crystal_drive_mode,
  output logic                   internal_osc_enable,
  input  wire logic              first_oscillator_pin_in,
  output logic                   first_pin_pullup_en,
  input  wire logic              second_oscillator_pin_in,
  output logic                   second_oscillator_pin_out,
  output logic                   second_oscillator_pin_oe_n,
  output logic                   irq,
  input  wire logic              i2c_rx_buffer_full,
  input  wire logic              i2c_scl_pull_low,
  input  wire logic              i2c_sda_pull_low,
  output logic                   i2c_scl_in,
  output logic                   i2c_sda_in,
  input  wire logic              pair_a_scl_pin_in,
  output logic                   pair_a_scl_pin_out,
  output logic                   pair_a_scl_pin_oe_n,
  input  wire logic              pair_a_sda_pin_in,
  output logic                   pair_a_sda_pin_out,
  output logic                   pair_a_sda_pin_oe_n,
  input  wire logic              pair_b_scl_pin_in,
  output logic                   pair_b_scl_pin_out,
  output logic                   pair_b_scl_pin_oe_n,
  input  wire logic              pair_b_sda_pin_in,
  output logic                   pair_b_sda_pin_out,
  output logic                   pair_b_sda_pin_oe_n,
  output logic                   smbus_threshold_select,
  output logic                   port_pair_a_ground_select,
  output logic                   port_pair_b_ground_select
);
  localparam int SW = `OMC_SYNC_W;
  localparam int EW = `OMC_EVT_W;

  omc_pkg::omc_osc_mode_type osc_mode_q;
  omc_pkg::omc_pair_type     pair_sel;

  logic [DATA_W-1:0] misc_q;
  logic [DATA_W-1:0] misc_d;
  logic [EW-1:0]     irq_stat_q;
  logic [EW-1:0]     irq_stat_d;
  logic [EW-1:0]     irq_mask_q;
  logic [EW-1:0]     irq_evt;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic [SW-1:0] pad_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;
  logic [SW-1:0] stable_q;

  logic internal_mode;
  logic pin1_level;
  logic pin1_level_prev_q;
  logic stretch_active;
  logic stretch_prev_q;
  logic scl_drive;
  logic sda_drive;
  logic pin2_out_q;
  logic pin2_oe_n_q;
  logic a_scl_oe_n_q;
  logic a_sda_oe_n_q;
  logic b_scl_oe_n_q;
  logic b_sda_oe_n_q;
  logic scl_in_q;
  logic sda_in_q;
  logic sel_misc;
  logic sel_stat;
  logic sel_mask;

  omc_div_if div_bus ();

  omc_clk_div #(
    .DIV_BITS (`OMC_DIV_BITS)
  ) u_clk_div (
    .mclk (mclk),
    .rst  (rst),
    .div  (div_bus.gen)
  );

  // The configuration bit is caught while reset is held, so software never
  // sees the mode change under it; it is a non-volatile setting in practice.
  always_ff @(posedge mclk) begin
    if (rst) begin
      if (osc_select_cfg) begin
        osc_mode_q <= omc_pkg::OMC_MODE_INTERNAL;
      end else begin
        osc_mode_q <= omc_pkg::OMC_MODE_CRYSTAL;
      end
    end
  end

  assign internal_mode       = (osc_mode_q == omc_pkg::OMC_MODE_INTERNAL);
  assign crystal_drive_mode  = !internal_mode;
  assign internal_osc_enable = internal_mode;
  assign first_pin_pullup_en = internal_mode;

  // Pad inputs pass three flops; a change is taken once the last two agree,
  // which keeps a single metastable sample from reaching the logic.
  assign pad_raw = {pair_b_sda_pin_in,
                    pair_b_scl_pin_in,
                    pair_a_sda_pin_in,
                    pair_a_scl_pin_in,
                    first_oscillator_pin_in};

  // The chain resets to the idle high level of every pad, so leaving reset
  // never looks like a press or like a pulled bus line.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
    end else begin
      sync1_q <= pad_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A lone disagreeing sample leaves the old level in place.
  always_ff @(posedge mclk) begin
    if (rst) begin
      stable_q <= '1;
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // In crystal mode both oscillator pins belong to the oscillator, so the
  // port bit reads low rather than showing a toggling crystal.
  assign pin1_level = internal_mode & stable_q[0];

  // Addresses are decoded in full, so no alias of a register answers.
  assign sel_misc = (reg_addr == `OMC_MISC_ADDR);
  assign sel_stat = (reg_addr == `OMC_IRQ_STAT_ADDR);
  assign sel_mask = (reg_addr == `OMC_IRQ_MASK_ADDR);

  // Bit 0 is input only, so its write is dropped and it always stores zero.
  always_comb begin
    misc_d = misc_q;
    if (reg_wr && sel_misc) begin
      misc_d = reg_wdata & `OMC_MISC_WR_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      misc_q <= `OMC_MISC_RESET;
    end else begin
      misc_q <= misc_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_mask_q <= EW'(`OMC_IRQ_RESET);
    end else if (reg_wr && sel_mask) begin
      irq_mask_q <= reg_wdata[EW-1:0];
    end
  end

  assign stretch_active = misc_q[`OMC_BIT_STRETCH] & i2c_rx_buffer_full;

  // The pin idles high under its pull-up, so the history starts high too.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin1_level_prev_q <= 1'b1;
    end else begin
      pin1_level_prev_q <= stable_q[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stretch_prev_q <= 1'b0;
    end else begin
      stretch_prev_q <= stretch_active;
    end
  end

  // A press pulls the input low against its pull-up, so the falling edge is
  // the event; it is ignored in crystal mode where the pin is a clock.
  always_comb begin
    irq_evt = '0;
    irq_evt[`OMC_EVT_PIN1] = internal_mode & pin1_level_prev_q & !stable_q[0];
    irq_evt[`OMC_EVT_STRETCH] = stretch_active & !stretch_prev_q;
  end

  // An event landing in the same cycle as its write-one clear stays set.
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (reg_wr && sel_stat) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[EW-1:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_q <= EW'(`OMC_IRQ_RESET);
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb begin
    rdata_d = '0;
    if (sel_misc) begin
      rdata_d = misc_q;
      rdata_d[`OMC_BIT_PIN1_IN] = pin1_level;
    end else if (sel_stat) begin
      rdata_d[EW-1:0] = irq_stat_q;
    end else if (sel_mask) begin
      rdata_d[EW-1:0] = irq_mask_q;
    end
  end

  // Read data stand only in the cycle after the strobe and are zero otherwise.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  assign div_bus.enable = internal_mode & misc_q[`OMC_BIT_CLKOUT_EN];

  // The clock output takes priority over the latch while enabled; the latch
  // keeps its value and reappears on the pin when the clock is disconnected.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin2_out_q  <= 1'b0;
      pin2_oe_n_q <= 1'b1;
    end else if (!internal_mode) begin
      pin2_out_q  <= 1'b0;
      pin2_oe_n_q <= 1'b1;
    end else if (misc_q[`OMC_BIT_CLKOUT_EN]) begin
      pin2_out_q  <= div_bus.div_clk;
      pin2_oe_n_q <= 1'b0;
    end else begin
      pin2_out_q  <= misc_d[`OMC_BIT_PIN2_OUT];
      pin2_oe_n_q <= 1'b0;
    end
  end

  assign second_oscillator_pin_out  = pin2_out_q;
  assign second_oscillator_pin_oe_n = pin2_oe_n_q;

  always_comb begin
    if (misc_q[`OMC_BIT_ROUTE]) begin
      pair_sel = omc_pkg::OMC_PAIR_B;
    end else begin
      pair_sel = omc_pkg::OMC_PAIR_A;
    end
  end

  // Stretching adds to the engine's own pull so a held bus is never released early.
  assign scl_drive = i2c_scl_pull_low | stretch_active;
  assign sda_drive = i2c_sda_pull_low;

  // Only the selected pair follows the engine; the other pair stays released.
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_scl_oe_n_q <= 1'b1;
      a_sda_oe_n_q <= 1'b1;
      b_scl_oe_n_q <= 1'b1;
      b_sda_oe_n_q <= 1'b1;
    end else begin
      unique case (pair_sel)
        omc_pkg::OMC_PAIR_A: begin
          a_scl_oe_n_q <= !scl_drive;
          a_sda_oe_n_q <= !sda_drive;
          b_scl_oe_n_q <= 1'b1;
          b_sda_oe_n_q <= 1'b1;
        end
        omc_pkg::OMC_PAIR_B: begin
          a_scl_oe_n_q <= 1'b1;
          a_sda_oe_n_q <= 1'b1;
          b_scl_oe_n_q <= !scl_drive;
          b_sda_oe_n_q <= !sda_drive;
        end
      endcase
    end
  end

  // The engine hears only the lines of the pair that it is routed to.
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_in_q <= 1'b1;
      sda_in_q <= 1'b1;
    end else begin
      unique case (pair_sel)
        omc_pkg::OMC_PAIR_A: begin
          scl_in_q <= stable_q[1];
          sda_in_q <= stable_q[2];
        end
        omc_pkg::OMC_PAIR_B: begin
          scl_in_q <= stable_q[3];
          sda_in_q <= stable_q[4];
        end
      endcase
    end
  end

  // Open-drain pins only ever drive low; the enable carries the data.
  assign pair_a_scl_pin_out  = 1'b0;
  assign pair_a_sda_pin_out  = 1'b0;
  assign pair_b_scl_pin_out  = 1'b0;
  assign pair_b_sda_pin_out  = 1'b0;
  assign pair_a_scl_pin_oe_n = a_scl_oe_n_q;
  assign pair_a_sda_pin_oe_n = a_sda_oe_n_q;
  assign pair_b_scl_pin_oe_n = b_scl_oe_n_q;
  assign pair_b_sda_pin_oe_n = b_sda_oe_n_q;
  assign i2c_scl_in          = scl_in_q;
  assign i2c_sda_in          = sda_in_q;

  // The threshold and ground selects steer analog pad circuits directly.
  assign smbus_threshold_select    = misc_q[`OMC_BIT_SMBUS_TH];
  assign port_pair_a_ground_select = misc_q[`OMC_BIT_GND_A];
  assign port_pair_b_ground_select = misc_q[`OMC_BIT_GND_B];

endmodule : omc_misc_ctrl

// ---- hdl/omc_pkg.sv ----
// Types shared by the oscillator and misc control block.
package omc_pkg;
  typedef enum logic {OMC_MODE_CRYSTAL, OMC_MODE_INTERNAL} omc_osc_mode_type;
  typedef enum logic {OMC_PAIR_A, OMC_PAIR_B} omc_pair_type;
endpackage : omc_pkg

// ---- tb/omc_misc_ctrl_bench.sv ----
// Self-checking bench for the oscillator and misc control block.
`timescale 1ns/10ps
module omc_misc_ctrl_bench;
  logic       mclk, rst, reg_wr, reg_rd, osc_select_cfg, press, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       i2c_rx_buffer_full, i2c_scl_pull_low, i2c_sda_pull_low, i2c_scl_in, i2c_sda_in;
  logic       crystal_drive_mode, internal_osc_enable, first_oscillator_pin_in;
  logic       first_pin_pullup_en, second_oscillator_pin_in, second_oscillator_pin_out;
  logic       second_oscillator_pin_oe_n, smbus_threshold_select;
  logic       pair_a_scl_pin_in, pair_a_scl_pin_out, pair_a_scl_pin_oe_n;
  logic       pair_a_sda_pin_in, pair_a_sda_pin_out, pair_a_sda_pin_oe_n;
  logic       pair_b_scl_pin_in, pair_b_scl_pin_out, pair_b_scl_pin_oe_n;
  logic       pair_b_sda_pin_in, pair_b_sda_pin_out, pair_b_sda_pin_oe_n;
  logic       port_pair_a_ground_select, port_pair_b_ground_select;
  logic       pin2_prev;
  int         mismatches, n_compared, cycles, n;
  omc_misc_ctrl u_omc_misc_ctrl (.*);
  omc_pad_model u_omc_pad_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  // Called at a clock edge, it judges what stood through the cycle that edge closes.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic do_reset(input logic cfg);
    @(posedge mclk);
    osc_select_cfg <= cfg;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
  endtask : do_reset
  task automatic t_crystal;
    do_reset(1'b0);
    chk({6'h00, crystal_drive_mode, internal_osc_enable}, 8'h02);
    wr(8'h9E, 8'h06);
    tick(1);
    chk({6'h00, second_oscillator_pin_oe_n, second_oscillator_pin_out}, 8'h02);
    rd(8'h9E, 8'h06);
    rd(8'hA0, 8'h00);
  endtask : t_crystal
  task automatic t_internal;
    do_reset(1'b1);
    chk({5'h00, crystal_drive_mode, internal_osc_enable, first_pin_pullup_en}, 8'h03);
    rd(8'h9E, 8'h01);
    rd(8'hA1, 8'h00);
    wr(8'h9E, 8'h02);
    tick(1);
    chk({6'h00, second_oscillator_pin_oe_n, second_oscillator_pin_out}, 8'h01);
    rd(8'h9E, 8'h03);
    wr(8'h9E, 8'h04);
    tick(2);
    n = 0;
    pin2_prev = 1'b0;
    repeat (16) begin
      @(posedge mclk);
      n += int'(second_oscillator_pin_out && !pin2_prev);
      pin2_prev = second_oscillator_pin_out;
    end
    chk(8'(n), 8'h04);
    wr(8'h9E, 8'h00);
    tick(2);
    chk({6'h00, second_oscillator_pin_oe_n, second_oscillator_pin_out}, 8'h00);
  endtask : t_internal
  task automatic t_button;
    wr(8'hA1, 8'h01);
    press <= 1'b1;
    tick(6);
    chk({7'h00, irq}, 8'h01);
    wr(8'h9E, 8'h01);
    rd(8'h9E, 8'h00);
    rd(8'hA0, 8'h01);
    press <= 1'b0;
    wr(8'hA0, 8'h01);
    tick(1);
    chk({7'h00, irq}, 8'h00);
    wr(8'hA1, 8'h00);
    press <= 1'b1;
    tick(6);
    chk({7'h00, irq}, 8'h00);
    rd(8'hA0, 8'h01);
    press <= 1'b0;
    wr(8'hA0, 8'h01);
  endtask : t_button
  task automatic t_serial;
    wr(8'h9E, 8'h80);
    i2c_rx_buffer_full <= 1'b1;
    tick(7);
    chk({5'h00, pair_a_scl_pin_oe_n, pair_b_scl_pin_oe_n, i2c_scl_in}, 8'h02);
    rd(8'hA0, 8'h02);
    wr(8'h9E, 8'h90);
    tick(7);
    chk({5'h00, pair_a_scl_pin_oe_n, pair_b_scl_pin_oe_n, i2c_scl_in}, 8'h04);
    wr(8'h9E, 8'h10);
    tick(2);
    chk({6'h00, pair_a_scl_pin_oe_n, pair_b_scl_pin_oe_n}, 8'h03);
    i2c_rx_buffer_full <= 1'b0;
    i2c_scl_pull_low <= 1'b1;
    i2c_sda_pull_low <= 1'b1;
    tick(7);
    chk({5'h00, pair_a_sda_pin_oe_n, pair_b_sda_pin_oe_n, i2c_sda_in}, 8'h04);
    i2c_scl_pull_low <= 1'b0;
    i2c_sda_pull_low <= 1'b0;
    wr(8'h9E, 8'h68);
    tick(1);
    chk({5'h00, smbus_threshold_select, port_pair_a_ground_select, port_pair_b_ground_select},
        8'h07);
    wr(8'h9E, 8'h08);
    tick(1);
    chk({5'h00, smbus_threshold_select, port_pair_a_ground_select, port_pair_b_ground_select},
        8'h04);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    rd(8'h9E, 8'h09);
  endtask : t_serial
  initial begin
    {rst, reg_wr, reg_rd, press, osc_select_cfg} = 5'h11;
    {reg_addr, reg_wdata} = 16'h0000;
    {i2c_rx_buffer_full, i2c_scl_pull_low, i2c_sda_pull_low} = 3'h0;
    {mismatches, n_compared, cycles} = '0;
    tick(2);
    t_crystal();
    t_internal();
    t_button();
    t_serial();
    give_verdict();
  end
endmodule : omc_misc_ctrl_bench

// ---- tb/omc_misc_ctrl_chk.sv ----
// Port assertions for the oscillator and misc control block.
`timescale 1ns/10ps
module omc_misc_ctrl_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       internal_osc_enable,
  input wire logic       second_oscillator_pin_out,
  input wire logic       second_oscillator_pin_oe_n,
  input wire logic       i2c_rx_buffer_full,
  input wire logic       i2c_scl_pull_low,
  input wire logic       pair_a_scl_pin_oe_n,
  input wire logic       pair_b_scl_pin_oe_n,
  input wire logic       smbus_threshold_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic misc_wr;
  logic en_q;
  assign misc_wr = reg_wr && reg_addr == 8'h9E;
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (misc_wr) begin
      en_q <= reg_wdata[2];
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_pin2_latch: assert property (misc_wr && internal_osc_enable && !reg_wdata[2] && !en_q
    |=> !second_oscillator_pin_oe_n && second_oscillator_pin_out == $past(reg_wdata[1]))
    else $error("second pin does not follow its latch");
  a_pin_crystal: assert property (!internal_osc_enable
    |-> second_oscillator_pin_oe_n && !second_oscillator_pin_out)
    else $error("second pin driven in crystal mode");
  a_stretch_none: assert property (!i2c_scl_pull_low && !i2c_rx_buffer_full
    |=> pair_a_scl_pin_oe_n && pair_b_scl_pin_oe_n)
    else $error("clock line held low without cause");
  a_one_pair: assert property (i2c_scl_pull_low |=> pair_a_scl_pin_oe_n != pair_b_scl_pin_oe_n)
    else $error("clock pull not on exactly one pair");
  a_irq_masked: assert property (reg_wr && reg_addr == 8'hA1 && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt high with all sources masked");
  a_status_width: assert property ($past(reg_rd && reg_addr == 8'hA0)
    |-> reg_rdata[7:2] == 6'h00)
    else $error("unused status bits read nonzero");
  a_clk_square: assert property ($rose(second_oscillator_pin_out) && en_q && internal_osc_enable
    ##1 en_q [*4] |-> $past(second_oscillator_pin_out, 3) && !$past(second_oscillator_pin_out, 2)
    && !$past(second_oscillator_pin_out) && second_oscillator_pin_out)
    else $error("clock output is not a period four square wave");
  a_smbus_follow: assert property (misc_wr |=> smbus_threshold_select == $past(reg_wdata[3]))
    else $error("threshold select does not follow its bit");
endmodule : omc_misc_ctrl_chk
bind omc_misc_ctrl omc_misc_ctrl_chk u_omc_misc_ctrl_chk (.*);

// ---- tb/omc_pad_model.sv ----
// Pad side model: button, crystal and pulled-up serial lines.
`timescale 1ns/10ps
module omc_pad_model (
  input  wire logic mclk,
  input  wire logic press,
  input  wire logic first_pin_pullup_en,
  input  wire logic second_oscillator_pin_out,
  input  wire logic second_oscillator_pin_oe_n,
  input  wire logic pair_a_scl_pin_oe_n,
  input  wire logic pair_a_sda_pin_oe_n,
  input  wire logic pair_b_scl_pin_oe_n,
  input  wire logic pair_b_sda_pin_oe_n,
  output logic      first_oscillator_pin_in,
  output logic      second_oscillator_pin_in,
  output logic      pair_a_scl_pin_in,
  output logic      pair_a_sda_pin_in,
  output logic      pair_b_scl_pin_in,
  output logic      pair_b_sda_pin_in
);
  logic xtal_q = 1'b0;
  // Without the pull-up or a press the pin carries the crystal swing, never a steady level.
  always @(posedge mclk) xtal_q <= !xtal_q;
  assign first_oscillator_pin_in  = press ? 1'b0 : (first_pin_pullup_en ? 1'b1 : xtal_q);
  assign second_oscillator_pin_in = second_oscillator_pin_oe_n ? !xtal_q : second_oscillator_pin_out;
  // Open-drain lines with pull-ups read high once released.
  assign pair_a_scl_pin_in = pair_a_scl_pin_oe_n;
  assign pair_a_sda_pin_in = pair_a_sda_pin_oe_n;
  assign pair_b_scl_pin_in = pair_b_scl_pin_oe_n;
  assign pair_b_sda_pin_in = pair_b_sda_pin_oe_n;
endmodule : omc_pad_model
